// File: shared/sc_flags_defs.svh
// register offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the package and the rtl files
`ifndef SC_FLAGS_DEFS_SVH
`define SC_FLAGS_DEFS_SVH

// byte addresses on the apb bus, one aligned word each
`define SC_CTRL_OFF 8'h00
`define SC_STAT_OFF 8'h04
`define SC_RXBUF_OFF 8'h08
`define SC_ETU_OFF 8'h0c
`define SC_IRQ_STAT_OFF 8'h10
`define SC_IRQ_MASK_OFF 8'h14
`define SC_TXBUF_OFF 8'h18

// control register fields
`define SC_CTRL_TE_BIT 0
`define SC_CTRL_GM_BIT 1
`define SC_CTRL_ODD_BIT 2
`define SC_CTRL_TRANSMIT_ADDRESS_BIT_BIT 3

// status register fields, also the layout of irq status and mask
`define SC_ST_MPB_BIT 0
`define SC_ST_TRANSMIT_END_FLAG_BIT 1
`define SC_ST_PER_BIT 2
`define SC_ST_ERS_BIT 3
`define SC_ST_OVERRUN_FLAG_BIT 4
`define SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT 5
`define SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT 6
`define SC_IRQ_W 7

// reset values
`define SC_ETU_RESET 16'h0174
`define SC_TRANSMIT_BUFFER_EMPTY_FLAG_RESET 1'b1
`define SC_TRANSMIT_END_FLAG_RESET 1'b1

// transmit end delays, in half elementary time units
`define SC_TRANSMIT_END_FLAG_HALF_ETU_GM0 5
`define SC_TRANSMIT_END_FLAG_HALF_ETU_GM1 2
`define SC_TIMER_W 20

`endif

// File: shared/sc_flags_pkg.sv
// types for the smart card status flag block
// assumes sc_flags_defs.svh on the include path
`include "sc_flags_defs.svh"

package sc_flags_pkg;

    typedef struct packed {
        logic busy;
        logic [`SC_TIMER_W-1:0] count;
        logic done;
    } timer_state_t;

    typedef struct packed {
        logic transmit_enable;
        logic short_guard_mode;
        logic parity_odd;
        logic transmit_address_bit;
        logic [15:0] etu_cycles;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [`SC_IRQ_W-1:0] flags;
        logic [`SC_IRQ_W-1:0] read_as_one;
        logic [`SC_IRQ_W-1:0] irq_status;
        logic [`SC_IRQ_W-1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } flags_state_t;

endpackage : sc_flags_pkg

// File: rtl/sc_transmit_end_flag_timer.sv
// one-shot cycle counter for the transmit end delay
// assumes start is a one-cycle pulse and cancel a level, both in the core clock domain
`timescale 1ns/1ps
`include "sc_flags_defs.svh"

module sc_transmit_end_flag_timer (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic cancel_in,
    input wire logic [`SC_TIMER_W-1:0] target_in,
    output logic done_out
);

    sc_flags_pkg::timer_state_t state_ff;
    sc_flags_pkg::timer_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        if (cancel_in) begin
            nxt_state.busy = 1'b0;
            nxt_state.count = '0;
        end else if (start_in) begin
            // a new character restarts the delay from its own end
            nxt_state.busy = 1'b1;
            nxt_state.count = '0;
        end else if (state_ff.busy) begin
            if (state_ff.count + `SC_TIMER_W'(1) >= target_in) begin
                nxt_state.busy = 1'b0;
                nxt_state.done = 1'b1;
            end else begin
                nxt_state.count = state_ff.count + `SC_TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign done_out = state_ff.done;

endmodule : sc_transmit_end_flag_timer

// File: rtl/sc_status_flags.sv
// status flag logic of a smart card serial unit, apb register slave
// assumes shifter events arrive as one-cycle pulses synchronous to core_clk_in
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "sc_flags_defs.svh"

module sc_status_flags (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // power states
    input wire logic standby_in,
    input wire logic module_stop_in,
    // transmit shifter side
    input wire logic tx_take_in,
    input wire logic tx_char_sent_in,
    input wire logic err_sample_in,
    input wire logic err_line_in,
    // receive shifter side
    input wire logic rx_done_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_parity_in,
    input wire logic rx_mpb_in,
    // transfer controller side
    input wire logic dma_tdr_write_in,
    input wire logic [7:0] dma_tdr_data_in,
    input wire logic dma_rdr_read_in,
    // to the shifters and the interrupt controller
    output logic [7:0] tx_data_out,
    output logic tx_mpb_out,
    output logic transmit_enable_out,
    output logic short_guard_mode_out,
    output logic parity_odd_out,
    output logic [7:0] rx_data_out,
    output logic transmit_buffer_empty_flag_out,
    output logic receive_buffer_full_flag_out,
    output logic overrun_flag_out,
    output logic error_signal_flag_out,
    output logic parity_error_flag_out,
    output logic transmit_end_flag_out,
    output logic received_address_bit_out,
    output logic irq_out
);

    sc_flags_pkg::flags_state_t state_ff;
    sc_flags_pkg::flags_state_t nxt_state;

    logic transmit_end_flag_timer_done;
    logic transmit_end_flag_timer_cancel;
    logic [`SC_TIMER_W-1:0] transmit_end_flag_target;
    logic [`SC_TIMER_W-1:0] etu_wide;
    logic [`SC_TIMER_W-1:0] half_etus;

    // target in cycles: half etus times etu, halved with truncation
    always_comb begin
        etu_wide = `SC_TIMER_W'(state_ff.etu_cycles);
        if (state_ff.short_guard_mode) begin
            half_etus = `SC_TIMER_W'(`SC_TRANSMIT_END_FLAG_HALF_ETU_GM1);
        end else begin
            half_etus = `SC_TIMER_W'(`SC_TRANSMIT_END_FLAG_HALF_ETU_GM0);
        end
        transmit_end_flag_target = `SC_TIMER_W'((etu_wide * half_etus) >> 1);
        if (transmit_end_flag_target == '0) begin
            transmit_end_flag_target = `SC_TIMER_W'(1);
        end
    end

    // a transmitter switched off or a power state abandons the pending delay
    assign transmit_end_flag_timer_cancel = !state_ff.transmit_enable || standby_in || module_stop_in;

    sc_transmit_end_flag_timer u_transmit_end_flag_timer (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .start_in(tx_char_sent_in),
        .cancel_in(transmit_end_flag_timer_cancel),
        .target_in(transmit_end_flag_target),
        .done_out(transmit_end_flag_timer_done)
    );

    logic apb_setup_access;
    logic apb_done;
    logic addr_known;
    logic [31:0] read_word;
    logic [`SC_IRQ_W-1:0] zero_written;
    logic [`SC_IRQ_W-1:0] flag_set;
    logic [`SC_IRQ_W-1:0] flag_clr;
    logic stat_write;
    logic rx_normal;
    logic rx_overrun;
    logic parity_bad;

    always_comb begin
        apb_setup_access = psel_in && penable_in && !state_ff.pready;
        apb_done = psel_in && penable_in && state_ff.pready;
        unique case (paddr_in)
            `SC_CTRL_OFF, `SC_STAT_OFF, `SC_RXBUF_OFF, `SC_ETU_OFF,
            `SC_IRQ_STAT_OFF, `SC_IRQ_MASK_OFF, `SC_TXBUF_OFF: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
        read_word = 32'h0000_0000;
        unique case (paddr_in)
            `SC_CTRL_OFF: begin
                read_word[`SC_CTRL_TE_BIT] = state_ff.transmit_enable;
                read_word[`SC_CTRL_GM_BIT] = state_ff.short_guard_mode;
                read_word[`SC_CTRL_ODD_BIT] = state_ff.parity_odd;
                read_word[`SC_CTRL_TRANSMIT_ADDRESS_BIT_BIT] = state_ff.transmit_address_bit;
            end
            `SC_STAT_OFF: read_word[`SC_IRQ_W-1:0] = state_ff.flags;
            `SC_RXBUF_OFF: read_word[7:0] = state_ff.rx_data;
            `SC_ETU_OFF: read_word[15:0] = state_ff.etu_cycles;
            `SC_IRQ_STAT_OFF: read_word[`SC_IRQ_W-1:0] = state_ff.irq_status;
            `SC_IRQ_MASK_OFF: read_word[`SC_IRQ_W-1:0] = state_ff.irq_mask;
            `SC_TXBUF_OFF: read_word[7:0] = state_ff.tx_data;
            default: read_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        stat_write = apb_done && pwrite_in && (paddr_in == `SC_STAT_OFF);
        // a zero only clears a flag that software has seen at one
        zero_written = '0;
        if (stat_write) begin
            zero_written = ~pwdata_in[`SC_IRQ_W-1:0] & state_ff.read_as_one;
        end
        rx_overrun = rx_done_in && state_ff.flags[`SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT];
        rx_normal = rx_done_in && !state_ff.flags[`SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT];
        parity_bad = (^{rx_data_in, rx_parity_in}) != state_ff.parity_odd;

        flag_set = '0;
        flag_clr = '0;

        // transmit empty
        flag_set[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT] = !state_ff.transmit_enable || tx_take_in;
        flag_clr[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT] = zero_written[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT] || dma_tdr_write_in;

        // transmit end
        flag_set[`SC_ST_TRANSMIT_END_FLAG_BIT] = standby_in || module_stop_in
            || (!state_ff.transmit_enable && !state_ff.flags[`SC_ST_ERS_BIT])
            || (transmit_end_flag_timer_done && state_ff.flags[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT]
                && !state_ff.flags[`SC_ST_ERS_BIT]);
        flag_clr[`SC_ST_TRANSMIT_END_FLAG_BIT] = zero_written[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT]
            || dma_tdr_write_in;

        // parity error
        flag_set[`SC_ST_PER_BIT] = rx_done_in && parity_bad;
        flag_clr[`SC_ST_PER_BIT] = zero_written[`SC_ST_PER_BIT];

        // error signal; transmit enable plays no part here
        flag_set[`SC_ST_ERS_BIT] = err_sample_in && !err_line_in;
        flag_clr[`SC_ST_ERS_BIT] = zero_written[`SC_ST_ERS_BIT]
            || standby_in || module_stop_in;

        // overrun keeps the old character in the buffer
        flag_set[`SC_ST_OVERRUN_FLAG_BIT] = rx_overrun;
        flag_clr[`SC_ST_OVERRUN_FLAG_BIT] = zero_written[`SC_ST_OVERRUN_FLAG_BIT];

        // receive full
        flag_set[`SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT] = rx_normal;
        flag_clr[`SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT] = zero_written[`SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT]
            || dma_rdr_read_in;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.pready = apb_setup_access;
        if (apb_setup_access) begin
            nxt_state.prdata = pwrite_in ? 32'h0000_0000 : read_word;
            nxt_state.pslverr = !addr_known;
        end

        // flags: a set in the clearing cycle wins
        nxt_state.flags = (state_ff.flags & ~flag_clr) | flag_set;
        // standby forces the error flag low even against a late sample
        if (standby_in || module_stop_in) begin
            nxt_state.flags[`SC_ST_ERS_BIT] = 1'b0;
        end
        nxt_state.flags[`SC_ST_MPB_BIT] = rx_normal ? rx_mpb_in
            : state_ff.flags[`SC_ST_MPB_BIT];
        if (rx_normal) begin
            nxt_state.rx_data = rx_data_in;
        end

        // read-as-one memory: a status read arms, a write disarms
        // arm from the word software got back, not from flags that moved since
        if (apb_done && !pwrite_in && paddr_in == `SC_STAT_OFF) begin
            nxt_state.read_as_one = state_ff.prdata[`SC_IRQ_W-1:0];
        end else if (stat_write) begin
            nxt_state.read_as_one = '0;
        end

        if (dma_tdr_write_in) begin
            nxt_state.tx_data = dma_tdr_data_in;
        end

        if (apb_done && pwrite_in) begin
            unique case (paddr_in)
                `SC_CTRL_OFF: begin
                    nxt_state.transmit_enable = pwdata_in[`SC_CTRL_TE_BIT];
                    nxt_state.short_guard_mode = pwdata_in[`SC_CTRL_GM_BIT];
                    nxt_state.parity_odd = pwdata_in[`SC_CTRL_ODD_BIT];
                    nxt_state.transmit_address_bit = pwdata_in[`SC_CTRL_TRANSMIT_ADDRESS_BIT_BIT];
                end
                `SC_ETU_OFF: nxt_state.etu_cycles = pwdata_in[15:0];
                `SC_IRQ_MASK_OFF: nxt_state.irq_mask = pwdata_in[`SC_IRQ_W-1:0];
                `SC_TXBUF_OFF: nxt_state.tx_data = pwdata_in[7:0];
                default: nxt_state.irq_mask = state_ff.irq_mask;
            endcase
        end

        // sticky events on each flag rising; write one clears, set wins
        nxt_state.irq_status = state_ff.irq_status;
        if (apb_done && pwrite_in && paddr_in == `SC_IRQ_STAT_OFF) begin
            nxt_state.irq_status = state_ff.irq_status & ~pwdata_in[`SC_IRQ_W-1:0];
        end
        nxt_state.irq_status = nxt_state.irq_status
            | (nxt_state.flags & ~state_ff.flags);
        // level output from a flop, loaded from the next status, so it changes in the same cycle as the status
        nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= '0;
            state_ff.etu_cycles <= `SC_ETU_RESET;
            state_ff.flags[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT] <= `SC_TRANSMIT_BUFFER_EMPTY_FLAG_RESET;
            state_ff.flags[`SC_ST_TRANSMIT_END_FLAG_BIT] <= `SC_TRANSMIT_END_FLAG_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata_out = state_ff.prdata;
    assign pready_out = state_ff.pready;
    assign pslverr_out = state_ff.pslverr;
    assign tx_data_out = state_ff.tx_data;
    assign tx_mpb_out = state_ff.transmit_address_bit;
    assign transmit_enable_out = state_ff.transmit_enable;
    assign short_guard_mode_out = state_ff.short_guard_mode;
    assign parity_odd_out = state_ff.parity_odd;
    assign rx_data_out = state_ff.rx_data;
    assign transmit_buffer_empty_flag_out = state_ff.flags[`SC_ST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT];
    assign receive_buffer_full_flag_out = state_ff.flags[`SC_ST_RECEIVE_BUFFER_FULL_FLAG_BIT];
    assign overrun_flag_out = state_ff.flags[`SC_ST_OVERRUN_FLAG_BIT];
    assign error_signal_flag_out = state_ff.flags[`SC_ST_ERS_BIT];
    assign parity_error_flag_out = state_ff.flags[`SC_ST_PER_BIT];
    assign transmit_end_flag_out = state_ff.flags[`SC_ST_TRANSMIT_END_FLAG_BIT];
    assign received_address_bit_out = state_ff.flags[`SC_ST_MPB_BIT];
    assign irq_out = state_ff.irq;

endmodule : sc_status_flags

// File: test/sc_status_flags_chk.sv
// concurrent checks on the status flag block, bound to its ports
// assumes shifter events are one-cycle pulses in the core clock domain
`timescale 1ns/1ps
`include "sc_flags_defs.svh"
module sc_status_flags_chk (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic standby_in,
    input wire logic module_stop_in,
    input wire logic tx_take_in,
    input wire logic err_sample_in,
    input wire logic err_line_in,
    input wire logic rx_done_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_parity_in,
    input wire logic rx_mpb_in,
    input wire logic dma_rdr_read_in,
    input wire logic parity_odd_out,
    input wire logic [7:0] rx_data_out,
    input wire logic transmit_buffer_empty_flag_out,
    input wire logic receive_buffer_full_flag_out,
    input wire logic overrun_flag_out,
    input wire logic error_signal_flag_out,
    input wire logic parity_error_flag_out,
    input wire logic transmit_end_flag_out,
    input wire logic received_address_bit_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    wire stop_any = standby_in || module_stop_in;
    wire stat_wr = psel_in && pwrite_in && (paddr_in == `SC_STAT_OFF);
    wire rx_new = rx_done_in && !receive_buffer_full_flag_out;

    property p_rx_mpb;
        rx_new |=> received_address_bit_out == $past(rx_mpb_in);
    endproperty
    a_rx_mpb: assert property (p_rx_mpb) else $error("address bit wrong");
    property p_rx_store;
        rx_new |=> receive_buffer_full_flag_out && rx_data_out == $past(rx_data_in);
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("buffer not filled");
    property p_overrun;
        rx_done_in && receive_buffer_full_flag_out && !dma_rdr_read_in |=> overrun_flag_out;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");
    property p_parity;
        rx_done_in && ((^rx_data_in ^ rx_parity_in) != parity_odd_out) |=> parity_error_flag_out;
    endproperty
    a_parity: assert property (p_parity) else $error("parity error missed");
    property p_err_set;
        err_sample_in && !err_line_in && !stop_any |=> error_signal_flag_out;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error signal missed");
    property p_err_stop;
        stop_any |=> !error_signal_flag_out;
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("error flag kept");
    property p_transmit_end_flag_stop;
        stop_any |=> transmit_end_flag_out;
    endproperty
    a_transmit_end_flag_stop: assert property (p_transmit_end_flag_stop) else $error("end flag not set");
    property p_transmit_buffer_empty_flag_set;
        tx_take_in |=> transmit_buffer_empty_flag_out;
    endproperty
    a_transmit_buffer_empty_flag_set: assert property (p_transmit_buffer_empty_flag_set) else $error("empty flag not set");
    property p_per_hold;
        $fell(parity_error_flag_out) |-> $past(stat_wr);
    endproperty
    a_per_hold: assert property (p_per_hold) else $error("parity flag lost");
    property p_overrun_flag_hold;
        overrun_flag_out && !stat_wr |=> overrun_flag_out;
    endproperty
    a_overrun_flag_hold: assert property (p_overrun_flag_hold) else $error("overrun flag lost");
endmodule : sc_status_flags_chk

bind sc_status_flags sc_status_flags_chk u_chk (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .psel_in(psel_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .standby_in(standby_in), .module_stop_in(module_stop_in), .tx_take_in(tx_take_in),
    .err_sample_in(err_sample_in), .err_line_in(err_line_in), .rx_done_in(rx_done_in),
    .rx_data_in(rx_data_in), .rx_parity_in(rx_parity_in), .rx_mpb_in(rx_mpb_in),
    .dma_rdr_read_in(dma_rdr_read_in), .parity_odd_out(parity_odd_out),
    .rx_data_out(rx_data_out),
    .transmit_buffer_empty_flag_out(transmit_buffer_empty_flag_out),
    .receive_buffer_full_flag_out(receive_buffer_full_flag_out),
    .overrun_flag_out(overrun_flag_out), .error_signal_flag_out(error_signal_flag_out),
    .parity_error_flag_out(parity_error_flag_out),
    .transmit_end_flag_out(transmit_end_flag_out),
    .received_address_bit_out(received_address_bit_out));

// File: test/sc_card_model.sv
// smart card side, reduced to the receive and error events of the shifters
// assumes tasks are called in the time step of a rising clock edge
`timescale 1ns/1ps
module sc_card_model (
    input wire logic clk_in,
    input wire logic parity_odd_in,
    output logic rx_done_out,
    output logic [7:0] rx_data_out,
    output logic rx_parity_out,
    output logic rx_mpb_out,
    output logic err_sample_out,
    output logic err_line_out
);
    initial begin
        rx_done_out = 1'b0;
        rx_data_out = 8'h00;
        rx_parity_out = 1'b0;
        rx_mpb_out = 1'b0;
        err_sample_out = 1'b0;
        err_line_out = 1'b1;
    end
    // bad flips the parity bit on purpose
    task automatic send_char(input logic [7:0] d, input logic received_address_bit, input logic bad);
        @(posedge clk_in);
        rx_done_out <= 1'b1;
        rx_data_out <= d;
        rx_mpb_out <= received_address_bit;
        rx_parity_out <= ^d ^ parity_odd_in ^ bad;
        @(posedge clk_in);
        rx_done_out <= 1'b0;
        // stale lines must not look valid
        rx_data_out <= ~d;
        rx_mpb_out <= ~received_address_bit;
        rx_parity_out <= ~rx_parity_out;
    endtask : send_char
    task automatic err_signal(input logic lvl);
        @(posedge clk_in);
        err_sample_out <= 1'b1;
        err_line_out <= lvl;
        @(posedge clk_in);
        err_sample_out <= 1'b0;
        // line has a pull-up, idles high
        err_line_out <= 1'b1;
    endtask : err_signal
endmodule : sc_card_model

// File: test/sc_status_flags_bench.sv
// self-checking bench for the smart card status flag block
// assumes a 40 mhz core clock; etu register is set to 4 cycles
`timescale 1ns/1ps
`include "sc_flags_defs.svh"
module sc_status_flags_bench;
    logic core_clk_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0] paddr_in, rx_data_in, dma_tdr_data_in, tx_data_out, rx_data_out;
    logic [31:0] pwdata_in, prdata_out, q;
    logic standby_in, module_stop_in, tx_take_in, tx_char_sent_in, err_sample_in, err_line_in;
    logic rx_done_in, rx_parity_in, rx_mpb_in, dma_tdr_write_in, dma_rdr_read_in, tx_mpb_out;
    logic transmit_enable_out, short_guard_mode_out, parity_odd_out, irq_out, e;
    logic transmit_buffer_empty_flag_out, receive_buffer_full_flag_out, overrun_flag_out;
    logic error_signal_flag_out, parity_error_flag_out, transmit_end_flag_out;
    logic received_address_bit_out;
    int fail_count = 0;
    int n_tests = 0;
    int t;
    localparam int etu_cyc = 4;
    localparam int rdr_rd = 0;
    localparam int tdr_wr = 1;
    localparam int take = 2;
    localparam int sent = 3;
    localparam int stby = 4;
    localparam int mstop = 5;

    sc_status_flags u_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .standby_in(standby_in), .module_stop_in(module_stop_in),
        .tx_take_in(tx_take_in), .tx_char_sent_in(tx_char_sent_in),
        .err_sample_in(err_sample_in), .err_line_in(err_line_in), .rx_done_in(rx_done_in),
        .rx_data_in(rx_data_in), .rx_parity_in(rx_parity_in), .rx_mpb_in(rx_mpb_in),
        .dma_tdr_write_in(dma_tdr_write_in), .dma_tdr_data_in(dma_tdr_data_in),
        .dma_rdr_read_in(dma_rdr_read_in), .tx_data_out(tx_data_out), .tx_mpb_out(tx_mpb_out),
        .transmit_enable_out(transmit_enable_out), .short_guard_mode_out(short_guard_mode_out),
        .parity_odd_out(parity_odd_out), .rx_data_out(rx_data_out),
        .transmit_buffer_empty_flag_out(transmit_buffer_empty_flag_out),
        .receive_buffer_full_flag_out(receive_buffer_full_flag_out),
        .overrun_flag_out(overrun_flag_out), .error_signal_flag_out(error_signal_flag_out),
        .parity_error_flag_out(parity_error_flag_out),
        .transmit_end_flag_out(transmit_end_flag_out),
        .received_address_bit_out(received_address_bit_out), .irq_out(irq_out));
    sc_card_model u_card (.clk_in(core_clk_in), .parity_odd_in(parity_odd_out),
        .rx_done_out(rx_done_in), .rx_data_out(rx_data_in), .rx_parity_out(rx_parity_in),
        .rx_mpb_out(rx_mpb_in), .err_sample_out(err_sample_in), .err_line_out(err_line_in));

    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge core_clk_in);
            i++;
        end while (pready_out !== 1'b1 && i < 20);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (pready_out !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // one-cycle strobe on the input chosen by n
    task automatic pulse(input int n);
        @(posedge core_clk_in);
        case (n)
            rdr_rd: dma_rdr_read_in <= 1'b1;
            tdr_wr: dma_tdr_write_in <= 1'b1;
            take: tx_take_in <= 1'b1;
            sent: tx_char_sent_in <= 1'b1;
            stby: standby_in <= 1'b1;
            default: module_stop_in <= 1'b1;
        endcase
        @(posedge core_clk_in);
        {dma_rdr_read_in, dma_tdr_write_in, tx_take_in, tx_char_sent_in} <= 4'h0;
        {standby_in, module_stop_in} <= 2'h0;
    endtask : pulse
    task automatic settle;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask : settle

    initial begin
        {resetn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {standby_in, module_stop_in, tx_take_in, tx_char_sent_in} = 4'h0;
        {dma_tdr_write_in, dma_tdr_data_in, dma_rdr_read_in} = '0;
        repeat (3) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        rd(`SC_STAT_OFF, 32'h42);
        rd(`SC_ETU_OFF, 32'h174);
        rd(8'h1c, 32'h0);
        chk(e, 1'b1);
        wr(`SC_ETU_OFF, etu_cyc);
        wr(`SC_CTRL_OFF, 32'h5);
        u_card.send_char(8'h5a, 1'b1, 1'b0);
        rd(`SC_STAT_OFF, 32'h63);
        rd(`SC_RXBUF_OFF, 32'h5a);
        u_card.send_char(8'hc3, 1'b0, 1'b1);
        rd(`SC_STAT_OFF, 32'h77);
        wr(`SC_STAT_OFF, 32'hff);
        wr(`SC_STAT_OFF, 32'h42);
        rd(`SC_STAT_OFF, 32'h77);
        wr(`SC_STAT_OFF, 32'h42);
        rd(`SC_STAT_OFF, 32'h43);
        u_card.send_char(8'h3c, 1'b0, 1'b0);
        rd(`SC_STAT_OFF, 32'h62);
        pulse(rdr_rd);
        rd(`SC_STAT_OFF, 32'h42);
        for (int gm = 0; gm < 2; gm++) begin
            wr(`SC_CTRL_OFF, {28'h0, gm[0], 1'b1, gm[0], 1'b1});
            dma_tdr_data_in <= {7'h48, gm[0]};
            @(negedge core_clk_in);
            chk(tx_mpb_out, gm[0]);
            chk({transmit_enable_out, short_guard_mode_out, parity_odd_out}, {1'b1, gm[0], 1'b1});
            // first pass: controller write; second: cpu write, then write-0 to the empty flag
            if (gm == 0) begin
                pulse(tdr_wr);
            end else begin
                wr(`SC_TXBUF_OFF, {24'h0, 7'h48, gm[0]});
                rd(`SC_STAT_OFF, 32'h42);
                wr(`SC_STAT_OFF, 32'hbf);
            end
            rd(`SC_STAT_OFF, 32'h0);
            rd(`SC_TXBUF_OFF, {24'h0, 7'h48, gm[0]});
            chk(tx_data_out, {7'h48, gm[0]});
            pulse(take);
            pulse(sent);
            // end delay in cycles: 2.5 or 1.0 etu, half cycles dropped
            t = gm ? etu_cyc : (etu_cyc * `SC_TRANSMIT_END_FLAG_HALF_ETU_GM0) / 2;
            repeat (t) @(posedge core_clk_in);
            @(negedge core_clk_in);
            chk(transmit_end_flag_out, 1'b0);
            @(negedge core_clk_in);
            chk(transmit_end_flag_out, 1'b1);
        end
        wr(`SC_IRQ_STAT_OFF, 32'h7f);
        wr(`SC_IRQ_MASK_OFF, 32'h0);
        pulse(tdr_wr);
        u_card.err_signal(1'b0);
        settle();
        chk(irq_out, 1'b0);
        wr(`SC_IRQ_MASK_OFF, 32'h8);
        settle();
        chk(irq_out, 1'b1);
        wr(`SC_CTRL_OFF, 32'h0);
        rd(`SC_STAT_OFF, 32'h48);
        wr(`SC_IRQ_STAT_OFF, 32'h8);
        settle();
        chk(irq_out, 1'b0);
        wr(`SC_STAT_OFF, 32'h42);
        rd(`SC_STAT_OFF, 32'h42);
        for (int k = 0; k < 2; k++) begin
            u_card.err_signal(1'b0);
            if (k == 1) begin
                pulse(mstop);
            end else begin
                pulse(stby);
            end
            rd(`SC_STAT_OFF, 32'h42);
        end
        wrap_up();
    end
endmodule : sc_status_flags_bench
